// ==== core/ricr_pkg.sv ====
// Purpose: Shared constants and carriers for the reference input configuration registers.
// Assumes: Byte-wide registers reached through a parallel access port on the system clock.
// Notes: Offsets are the byte addresses of the serial register map.
package ricr_pkg;

   // Register offsets.
   localparam logic [7:0] RX_BG_OFS = 8'h1a;
   localparam logic [7:0] CRYSTAL_CAP_OFS = 8'h1b;
   localparam logic [7:0] SPARE_1C_OFS = 8'h1c;
   localparam logic [7:0] SPARE_1D_OFS = 8'h1d;
   localparam logic [7:0] SPARE_1E_OFS = 8'h1e;
   localparam logic [7:0] DIV_HI_OFS = 8'h1f;
   localparam logic [7:0] DIV_LO_OFS = 8'h20;
   localparam logic [7:0] DBL_PRE_OFS = 8'h21;
   localparam logic [7:0] SPARE_22_OFS = 8'h22;

   // Field positions in the receiver reset and bandgap register.
   localparam int RX_RESET_BIT = 7;
   localparam int BG_ADJ_MSB = 6;
   localparam int BG_ADJ_LSB = 2;
   localparam int BG_OVR_BIT = 0;

   // Field positions in the crystal tuning capacitance register.
   localparam int CAP_AUTO_BIT = 7;
   localparam int CAP_RSVD_BIT = 6;
   localparam int CAP_CODE_MSB = 5;
   localparam int CAP_CODE_LSB = 0;

   // Field positions in the divider and doubler/prescaler registers.
   localparam int DIV_LO_MSB = 7;
   localparam int DIV_LO_LSB = 2;
   localparam int DIV_OVR_BIT = 1;
   localparam int DBL_OVR_BIT = 7;
   localparam int DBL_SEL_BIT = 6;
   localparam int PRE_OVR_BIT = 5;
   localparam int PRE_SEL_BIT = 4;

   // Values after reset.
   localparam logic [4:0] BG_ADJ_RST = 5'h00;
   localparam logic [5:0] CAP_CODE_RST = 6'h00;
   localparam logic [13:0] DIV_RST = 14'h0800;
   localparam logic CAP_AUTO_RST = 1'b1;

   // Cycles the reference input hardware reset is held after a set.
   localparam logic [3:0] RX_RESET_CYCLES = 4'h8;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ricr_req_t;

   // Values chosen automatically by the strap decode when no override is set.
   typedef struct packed {
      logic [4:0] bandgap;
      logic [5:0] cap_code;
      logic [13:0] divider;
      logic doubler;
      logic prescaler;
   } ricr_auto_t;

   // Settings applied to the reference input section.
   typedef struct packed {
      logic rx_reset;
      logic [4:0] bandgap;
      logic [5:0] cap_code;
      logic [5:0] cap_qpf;
      logic [13:0] divider;
      logic doubler;
      logic prescaler;
   } ricr_cfg_t;

endpackage

// ==== core/ricr_regs.sv ====
// Purpose: Configuration registers for the reference input, bandgap and crystal sections.
// Assumes: The serial host decoder presents requests on the system clock; strap
// decode values arrive from logic on the same clock.
// Notes: Applied settings follow the registers one clock after a write.
// Function
// - Receiver reset bit clears itself after being set.
// - Writing one resets the reference input hardware; zero is normal operation.
// - Five-bit bandgap adjust in bits 6:2, default zero.
// - Override bit zero selects automatic bandgap, adjust field ignored.
// - Override bit one applies the stored adjust field.
// - Capacitance disable bit defaults one (automatic); zero uses tuning field.
// - Tuning code is inverted binary, quarter picofarad per step.
// - Fourteen-bit divider: bits 13:6 high register, 5:0 in bits 7:2.
// - Stored divider defaults to 2048.
// - Stored divider applies only with override bit one; else straps decide.
// - With override set, register divider replaces the strap divider.
// - Doubler automatic unless override bit 7; then bit 6 selects.
// - Doubler select has no effect without its override.
// - Prescaler automatic unless override bit 5; then bit 4 selects.
`timescale 1ns/1ps

module ricr_regs (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Register access from the serial host decoder
   input wire ricr_pkg::ricr_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   // Strap-derived automatic settings
   input wire ricr_pkg::ricr_auto_t auto_cfg,
   // Applied configuration
   output ricr_pkg::ricr_cfg_t cfg
);

   logic [3:0] rx_cnt_r;
   logic [4:0] bg_adj_r;
   logic bg_ovr_r;
   logic cap_auto_r;
   logic [5:0] cap_code_r;
   logic [13:0] div_r;
   logic div_ovr_r;
   logic dbl_ovr_r;
   logic dbl_sel_r;
   logic pre_ovr_r;
   logic pre_sel_r;
   logic [7:0] rd_nxt;
   logic [5:0] cap_nxt;

   function automatic logic wr_hit(input ricr_pkg::ricr_req_t r, input logic [7:0] ofs);
      wr_hit = r.wr && (r.addr == ofs);
   endfunction

   // The reset is stretched so every piece of the input section sees it;
   // a new write of one to bit 7 during the pulse restarts the count.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_cnt_r <= 4'h0;
      end else if (wr_hit(req, ricr_pkg::RX_BG_OFS) && req.wdata[ricr_pkg::RX_RESET_BIT]) begin
         rx_cnt_r <= ricr_pkg::RX_RESET_CYCLES;
      end else if (rx_cnt_r != 4'h0) begin
         rx_cnt_r <= rx_cnt_r - 4'h1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bg_adj_r <= ricr_pkg::BG_ADJ_RST;
         bg_ovr_r <= 1'b0;
      end else if (wr_hit(req, ricr_pkg::RX_BG_OFS)) begin
         bg_adj_r <= req.wdata[ricr_pkg::BG_ADJ_MSB:ricr_pkg::BG_ADJ_LSB];
         bg_ovr_r <= req.wdata[ricr_pkg::BG_OVR_BIT];
      end
   end

   // Bit 6 is not stored, so a host that breaks the write-zero convention
   // cannot disturb the oscillator.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cap_auto_r <= ricr_pkg::CAP_AUTO_RST;
         cap_code_r <= ricr_pkg::CAP_CODE_RST;
      end else if (wr_hit(req, ricr_pkg::CRYSTAL_CAP_OFS)) begin
         cap_auto_r <= req.wdata[ricr_pkg::CAP_AUTO_BIT];
         cap_code_r <= req.wdata[ricr_pkg::CAP_CODE_MSB:ricr_pkg::CAP_CODE_LSB];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         div_r <= ricr_pkg::DIV_RST;
         div_ovr_r <= 1'b0;
      end else if (wr_hit(req, ricr_pkg::DIV_HI_OFS)) begin
         div_r[13:6] <= req.wdata;
      end else if (wr_hit(req, ricr_pkg::DIV_LO_OFS)) begin
         div_r[5:0] <= req.wdata[ricr_pkg::DIV_LO_MSB:ricr_pkg::DIV_LO_LSB];
         div_ovr_r <= req.wdata[ricr_pkg::DIV_OVR_BIT];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dbl_ovr_r <= 1'b0;
         dbl_sel_r <= 1'b0;
         pre_ovr_r <= 1'b0;
         pre_sel_r <= 1'b0;
      end else if (wr_hit(req, ricr_pkg::DBL_PRE_OFS)) begin
         dbl_ovr_r <= req.wdata[ricr_pkg::DBL_OVR_BIT];
         dbl_sel_r <= req.wdata[ricr_pkg::DBL_SEL_BIT];
         pre_ovr_r <= req.wdata[ricr_pkg::PRE_OVR_BIT];
         pre_sel_r <= req.wdata[ricr_pkg::PRE_SEL_BIT];
      end
   end

   always_comb begin
      rd_nxt = 8'h00;
      unique case (req.addr)
         ricr_pkg::RX_BG_OFS: begin
            rd_nxt = {(rx_cnt_r != 4'h0), bg_adj_r, 1'b0, bg_ovr_r};
         end
         ricr_pkg::CRYSTAL_CAP_OFS: begin
            rd_nxt = {cap_auto_r, 1'b0, cap_code_r};
         end
         ricr_pkg::DIV_HI_OFS: begin
            rd_nxt = div_r[13:6];
         end
         ricr_pkg::DIV_LO_OFS: begin
            rd_nxt = {div_r[5:0], div_ovr_r, 1'b0};
         end
         ricr_pkg::DBL_PRE_OFS: begin
            rd_nxt = {dbl_ovr_r, dbl_sel_r, pre_ovr_r, pre_sel_r, 4'h0};
         end
         default: begin
            rd_nxt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd;
         rdata <= req.rd ? rd_nxt : 8'h00;
      end
   end

   assign cap_nxt = cap_auto_r ? auto_cfg.cap_code : cap_code_r;

   // Applied settings are registered so the analog controls never see a
   // combinational glitch while an override is being changed.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cfg <= '0;
      end else begin
         cfg.rx_reset <= (rx_cnt_r != 4'h0);
         cfg.bandgap <= bg_ovr_r ? bg_adj_r : auto_cfg.bandgap;
         cfg.cap_code <= cap_nxt;
         cfg.cap_qpf <= ~cap_nxt;
         cfg.divider <= div_ovr_r ? div_r : auto_cfg.divider;
         cfg.doubler <= dbl_ovr_r ? dbl_sel_r : auto_cfg.doubler;
         cfg.prescaler <= pre_ovr_r ? pre_sel_r : auto_cfg.prescaler;
      end
   end

endmodule

// ==== sim/ricr_host.sv ====
// Purpose: Host model issuing byte register transfers.
// Assumes: One strobe cycle, then one idle cycle.
// Notes: Idle lines carry inverted values so stale data never looks valid.
`timescale 1ns/1ps
module ricr_host (
   // Clock
   input wire logic clock,
   // Request
   output ricr_pkg::ricr_req_t req
);
   initial req = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{wr: w, rd: !w, addr: a, wdata: (a == 8'h1b) ? d & 8'hbf : d};
      @(posedge clock);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule

// ==== sim/ricr_regs_tb_top.sv ====
// Purpose: Self-checking bench for the reference input registers.
// Assumes: Strap values change randomly every cycle.
// Notes: Reads are checked in order against a queue of expected bytes.
`timescale 1ns/1ps
module ricr_regs_tb_top;
   logic clock;
   logic rstn;
   ricr_pkg::ricr_req_t req;
   ricr_pkg::ricr_auto_t auto_cfg = '0;
   ricr_pkg::ricr_cfg_t cfg;
   logic [7:0] rdata;
   logic rvalid;
   logic [7:0] exp_q[$];
   logic [7:0] adr[5] = '{8'h1a, 8'h1b, 8'h1f, 8'h20, 8'h21};
   logic [7:0] msk[5] = '{8'h7d, 8'hbf, 8'hff, 8'hfe, 8'hf0};
   logic [7:0] shd[5] = '{8'h00, 8'h80, 8'h20, 8'h00, 8'h00};
   logic [7:0] rstv[5] = '{8'h00, 8'h80, 8'h20, 8'h00, 8'h00};
   logic [7:0] spare[6] = '{8'h1c, 8'h1d, 8'h1e, 8'h22, 8'h00, 8'hff};
   int error_cnt = 0;
   int checked = 0;
   ricr_regs i_dut (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
      .auto_cfg(auto_cfg), .cfg(cfg));
   ricr_host i_host (.clock(clock), .req(req));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) auto_cfg <= ricr_pkg::ricr_auto_t'(27'($urandom));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.xfer(1'b0, a, 8'h00);
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(negedge clock) begin
      if (rvalid === 1'b1) chk("rdata", rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
   end
   initial begin
      int k;
      logic [7:0] v;
      void'($urandom(24));
      rstn = 1'b0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      foreach (adr[i]) rd(adr[i], shd[i]);
      foreach (spare[i]) begin
         i_host.xfer(1'b1, spare[i], 8'hff);
         rd(spare[i], 8'h00);
      end
      $display("test reset values and spares done");
      // Bit 7 of the first register is kept clear so no reset starts here.
      repeat (40) begin
         k = $urandom_range(4);
         v = 8'($urandom) & (k == 0 ? 8'h7f : 8'hff);
         i_host.xfer(1'b1, adr[k], v);
         shd[k] = v & msk[k];
         rd(adr[k], shd[k]);
      end
      $display("test write and read back done");
      i_host.xfer(1'b1, 8'h1a, 8'h80 | shd[0]);
      rd(8'h1a, 8'h80 | shd[0]);
      repeat (12) @(posedge clock);
      rd(8'h1a, shd[0]);
      $display("test receiver reset done");
      // A reset in the middle of a receiver reset pulse must clear the count as well.
      i_host.xfer(1'b1, 8'h1a, 8'h80);
      repeat (2) @(posedge clock);
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      foreach (adr[i]) rd(adr[i], rstv[i]);
      $display("test reset in mid-run done");
      repeat (4) @(posedge clock);
      chk("pending reads", 8'(exp_q.size()), 8'h00);
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      conclude();
   end
endmodule

// ==== sim/ricr_sva.sv ====
// Purpose: Port checks for the reference input registers.
// Assumes: Shadows follow host writes, masked to stored bits.
// Notes: Applied fields lag the registers by one edge.
`timescale 1ns/1ps
module ricr_sva (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Watched ports
   input wire ricr_pkg::ricr_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire ricr_pkg::ricr_auto_t auto_cfg,
   input wire ricr_pkg::ricr_cfg_t cfg
);
   logic [7:0] a_r, b_r, f_r, l_r, d_r;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {a_r, b_r, f_r, l_r, d_r} <= 40'h0080200000;
      end else if (req.wr) begin
         case (req.addr)
            8'h1a: a_r <= req.wdata & 8'h7d;
            8'h1b: b_r <= req.wdata & 8'hbf;
            8'h1f: f_r <= req.wdata;
            8'h20: l_r <= req.wdata & 8'hfe;
            8'h21: d_r <= req.wdata & 8'hf0;
            default: ;
         endcase
      end
   end
   rst_hold_a: assert property (
      req.wr && req.addr == 8'h1a && req.wdata[7] |=> ##1 cfg.rx_reset [*8]) else $error("reset short");
   rst_clear_a: assert property ($rose(cfg.rx_reset) |-> ##8 !cfg.rx_reset) else $error("reset stuck");
   bg_pick_a: assert property (
      $past(rstn) |-> cfg.bandgap == $past(a_r[0] ? a_r[6:2] : auto_cfg.bandgap)) else $error("bad bandgap");
   cap_pick_a: assert property (
      $past(rstn) |-> cfg.cap_code == $past(b_r[7] ? auto_cfg.cap_code : b_r[5:0])) else $error("bad cap");
   cap_units_a: assert property (
      $past(rstn) |-> cfg.cap_qpf == ~cfg.cap_code) else $error("bad cap units");
   div_pick_a: assert property (
      $past(rstn) |-> cfg.divider == $past(l_r[1] ? {f_r, l_r[7:2]} : auto_cfg.divider)) else $error("bad div");
   dbl_pick_a: assert property (
      $past(rstn) |-> cfg.doubler == $past(d_r[7] ? d_r[6] : auto_cfg.doubler)) else $error("bad doubler");
   pre_pick_a: assert property (
      $past(rstn) |-> cfg.prescaler == $past(d_r[5] ? d_r[4] : auto_cfg.prescaler)) else $error("bad prescaler");
   cover property ($rose(cfg.rx_reset));
   cover property (l_r[1] && rvalid);
   cover property (d_r[7] && d_r[5]);
endmodule
bind ricr_regs ricr_sva i_sva (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata), .rvalid(rvalid),
   .auto_cfg(auto_cfg), .cfg(cfg));
